// ===== bench/scrm_host.sv
// ----------------------------------------
// Host controller issuing control words
// ----------------------------------------
module scrm_host (
  input wire logic clock,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // Word carries its select code in the low nibble; data goes out as given, reserved words included
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  // Single read, holding rready until the data is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : scrm_host

// ===== bench/synth_control_register_map_test.sv
module synth_control_register_map_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scrm_pkg::*;
  localparam logic [24:0] FRAC = 25'h1ABCDEF;
  localparam logic [31:0] FUNCW = 32'hA5A5_5A56;
  localparam logic [23:0] FRAC2W = 24'h123456;
  localparam logic [23:0] MOD2W = 24'hFEDCBA;
  localparam logic [31:0] CLK2W = 32'h0F0F_1237;
  logic clock = 1'b0;
  logic rstB = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] intDivide;
  logic modKind, fixedMod, updatePulse;
  logic [24:0] fracOne;
  logic [23:0] fracTwo, modTwo;
  logic [31:0] funcSet, clkTwo;
  int nFail = 0;
  int checksDone = 0;
  int pulses = 0;
  int cycles = 0;
  // ----------------------------------------
  // Clock, pulse count and hang guard
  // ----------------------------------------
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (updatePulse === 1'b1) pulses <= pulses + 1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nFail = nFail + 1;
      finishTest();
    end
  end
  scrm_host host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  scrm_regmap dut (.clock(clock), .rst_b(rstB), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .intDivide(intDivide), .modulusKindSelect(modKind), .fixedModulusActive(fixedMod),
    .fracOneActive(fracOne), .fracTwoActive(fracTwo), .modTwoActive(modTwo),
    .functionSettings(funcSet), .secondClockSettings(clkTwo), .updatePulse(updatePulse));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone = checksDone + 1;
    if (seen !== exp) begin
      nFail = nFail + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finishTest
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rstB <= 1'b1;
    #1 chk(fixedMod, 1'b1);
    chk(intDivide, 16'h0000);
    host.wr(OFS_CTRL_WORD, {3'h0, FRAC, SEL_FRAC1}, rs);
    host.wr(OFS_CTRL_WORD, FUNCW, rs);
    host.wr(OFS_CTRL_WORD, {4'h0, FRAC2W, SEL_FRAC2}, rs);
    host.wr(OFS_CTRL_WORD, {4'h0, MOD2W, SEL_MOD2}, rs);
    host.wr(OFS_CTRL_WORD, CLK2W, rs);
    #1 chk(fracOne, 25'h0);
    chk(fracTwo, 24'h0);
    chk(modTwo, 24'h0);
    chk(funcSet, 32'h0);
    chk(clkTwo, 32'h0);
    chk(pulses, 32'h0);
    host.rd(OFS_SHADOW_BASE + 8'h18, rd, rs);
    chk(rd, FUNCW);
    host.rd(OFS_SHADOW_BASE + 8'h1C, rd, rs);
    chk(rd, CLK2W);
    host.wr(OFS_CTRL_WORD, {3'h0, 1'b1, 8'h00, 16'hBEEF, SEL_INT}, rs);
    #1 chk(intDivide, 16'hBEEF);
    chk(modKind, 1'b1);
    chk(fixedMod, 1'b0);
    chk(fracOne, FRAC);
    chk(fracTwo, FRAC2W);
    chk(modTwo, MOD2W);
    chk(funcSet, FUNCW);
    chk(clkTwo, CLK2W);
    chk(pulses, 32'h1);
    host.rd(OFS_ACTIVE_INT, rd, rs);
    chk(rd, 32'h1000_BEEF);
    host.rd(OFS_ACTIVE_FRAC1, rd, rs);
    chk(rd, {7'h00, FRAC});
    host.wr(OFS_CTRL_WORD, {3'h0, 1'b0, 8'h00, 16'h0001, SEL_INT}, rs);
    #1 chk(fixedMod, 1'b1);
    chk(modKind, 1'b0);
    chk(intDivide, 16'h0001);
    // A write away from the control word offset is refused and moves nothing
    host.wr(OFS_ACTIVE_INT, {28'h0000000, SEL_INT}, rs);
    chk(rs, RESP_SLVERR);
    chk(pulses, 32'h2);
    // Reserved words receive zero data only
    host.wr(OFS_CTRL_WORD, {28'h0, SEL_RSV8}, rs);
    chk(rs, RESP_OKAY);
    host.wr(OFS_CTRL_WORD, {28'h0, SEL_RSV10}, rs);
    chk(rs, RESP_OKAY);
    host.wr(OFS_CTRL_WORD, {28'h0, SEL_RSV13}, rs);
    host.rd(OFS_STATUS, rd, rs);
    chk(rd, 32'h0000_0002);
    // Deliberate nonzero reserved data must raise the sticky flag
    host.wr(OFS_CTRL_WORD, {28'h0000001, SEL_RSV8}, rs);
    host.wr(OFS_CTRL_WORD, {28'h8000000, SEL_RSV13}, rs);
    host.rd(OFS_STATUS, rd, rs);
    chk(rd, 32'h0000_0102);
    host.wr(OFS_CTRL_WORD, 32'h0000_123E, rs);
    chk(rs, RESP_SLVERR);
    host.rd(8'h10, rd, rs);
    chk(rs, RESP_SLVERR);
    host.rd(8'h80, rd, rs);
    chk(rs, RESP_SLVERR);
    finishTest();
  end
endmodule : synth_control_register_map_test

// ===== include/scrm_pkg.sv
package scrm_pkg;

  // Register select codes carried in the low four bits of a control word
  localparam logic [3:0] SEL_INT = 4'h0;
  localparam logic [3:0] SEL_FRAC1 = 4'h1;
  localparam logic [3:0] SEL_PHASE = 4'h2;
  localparam logic [3:0] SEL_FRAC2 = 4'h3;
  localparam logic [3:0] SEL_MOD2 = 4'h4;
  localparam logic [3:0] SEL_RDIV = 4'h5;
  localparam logic [3:0] SEL_FUNC = 4'h6;
  localparam logic [3:0] SEL_CLK2 = 4'h7;
  localparam logic [3:0] SEL_RSV8 = 4'h8;
  localparam logic [3:0] SEL_LOCKB = 4'h9;
  localparam logic [3:0] SEL_RSV10 = 4'hA;
  localparam logic [3:0] SEL_RSV11 = 4'hB;
  localparam logic [3:0] SEL_OUTSEL = 4'hC;
  localparam logic [3:0] SEL_RSV13 = 4'hD;
  localparam int NUM_WORDS = 14;

  // AXI4-Lite byte offsets
  localparam logic [7:0] OFS_CTRL_WORD = 8'h00;
  localparam logic [7:0] OFS_ACTIVE_INT = 8'h04;
  localparam logic [7:0] OFS_ACTIVE_FRAC1 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_SHADOW_BASE = 8'h40;

  // Field positions inside the integer word
  localparam int MODK_BIT = 28;
  localparam int INTV_LSB = 4;
  localparam int INTV_MSB = 19;
  localparam int FIXED_MOD_BITS = 25;

  // Values after reset
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] INTV_RST = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : scrm_pkg

// ===== rtl/scrm_regmap.sv
// Functional notes
// - Active frequency settings change only when the integer word is written.
// - Modulus select bit 28 clear selects the fixed 25-bit modulus.
// - Modulus select bit 28 set selects the variable modulus scheme.
// - Integer divide value is word bits 19 to 4, unsigned 16 bits.
// - Double-buffered fields land in a holding stage, applied on the update event.
// - Map reaches word 13; words 10 and 13 reserved, host writes zero data.
// - Words 5 to 9 grouped; word 8 reserved zero; 6 and 7 hold settings.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module scrm_regmap (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [15:0] intDivide,
  output logic modulusKindSelect,
  output logic fixedModulusActive,
  output logic [24:0] fracOneActive,
  output logic [23:0] fracTwoActive,
  output logic [23:0] modTwoActive,
  output logic [31:0] functionSettings,
  output logic [31:0] secondClockSettings,
  output logic updatePulse
);
  import scrm_pkg::*;

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [NUM_WORDS-1:0][31:0] shadow;
    logic [15:0] intDivide;
    logic modKind;
    logic fixedMod;
    logic [24:0] frac1;
    logic [23:0] frac2;
    logic [23:0] mod2;
    logic [31:0] funcSet;
    logic [31:0] clk2Set;
    logic update;
    logic rsvdViolation;
    logic [7:0] updateCount;
    logic awReady;
    logic wReady;
    logic arReady;
  } scrm_state_s;

  scrm_state_s st_q;
  scrm_state_s st_d;

  logic doWrite;
  logic [3:0] wordSel;
  logic [3:0] rdIdx;
  logic intWrite;

  assign doWrite = st_q.awHave && st_q.wHave && !st_q.bValid;
  assign wordSel = st_q.wData[3:0];
  assign intWrite = doWrite && st_q.awAddr == OFS_CTRL_WORD && wordSel == SEL_INT;

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.update = 1'b0;
    // Address and data are caught independently
    if (awvalid && !st_q.awHave) begin
      st_d.awHave = 1'b1;
      st_d.awAddr = awaddr;
    end
    if (wvalid && !st_q.wHave) begin
      st_d.wHave = 1'b1;
      st_d.wData = wdata;
    end
    if (st_q.bValid && bready) begin
      st_d.bValid = 1'b0;
    end
    if (doWrite) begin
      st_d.awHave = 1'b0;
      st_d.wHave = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = RESP_OKAY;
      if (st_q.awAddr != OFS_CTRL_WORD) begin
        st_d.bResp = RESP_SLVERR;
      end else if (int'(wordSel) >= NUM_WORDS) begin
        st_d.bResp = RESP_SLVERR;
      end else begin
        // Word goes only to the register its select code names
        st_d.shadow[wordSel] = st_q.wData;
        // Reserved words must carry zero data bits
        if ((wordSel == SEL_RSV8 || wordSel == SEL_RSV10 || wordSel == SEL_RSV13)
            && st_q.wData[31:4] != 28'h0000000) begin
          st_d.rsvdViolation = 1'b1;
        end
        if (wordSel == SEL_INT) begin
          // Integer word write releases the held FRAC1, FRAC2, MOD2, function and second clock words at once
          st_d.intDivide = st_q.wData[INTV_MSB:INTV_LSB];
          st_d.modKind = st_q.wData[MODK_BIT];
          st_d.fixedMod = !st_q.wData[MODK_BIT];
          st_d.frac1 = st_q.shadow[SEL_FRAC1][28:4];
          st_d.frac2 = st_q.shadow[SEL_FRAC2][27:4];
          st_d.mod2 = st_q.shadow[SEL_MOD2][27:4];
          st_d.funcSet = st_q.shadow[SEL_FUNC];
          st_d.clk2Set = st_q.shadow[SEL_CLK2];
          st_d.update = 1'b1;
          st_d.updateCount = st_q.updateCount + 8'h01;
        end
      end
    end
    // Read channel
    if (st_q.rValid && rready) begin
      st_d.rValid = 1'b0;
    end
    if (arvalid && !st_q.rValid) begin
      st_d.rValid = 1'b1;
      st_d.rResp = RESP_OKAY;
      st_d.rData = 32'h0000_0000;
      if (araddr == OFS_ACTIVE_INT) begin
        st_d.rData = {3'h0, st_q.modKind, 12'h000, st_q.intDivide};
      end else if (araddr == OFS_ACTIVE_FRAC1) begin
        st_d.rData = {7'h00, st_q.frac1};
      end else if (araddr == OFS_STATUS) begin
        st_d.rData = {23'h000000, st_q.rsvdViolation, st_q.updateCount};
      end else if (araddr >= OFS_SHADOW_BASE && araddr[1:0] == 2'h0
                   && araddr < OFS_SHADOW_BASE + 8'(4 * NUM_WORDS)) begin
        st_d.rData = st_q.shadow[rdIdx];
      end else if (araddr == OFS_CTRL_WORD) begin
        st_d.rData = 32'h0000_0000;
      end else begin
        st_d.rResp = RESP_SLVERR;
      end
    end
    // Ready flags kept as flip-flops so the ports need no gate after them
    st_d.awReady = !st_d.awHave;
    st_d.wReady = !st_d.wHave;
    st_d.arReady = !st_d.rValid;
  end

  assign rdIdx = 4'((araddr - OFS_SHADOW_BASE) >> 2);

  //----------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.fixedMod <= 1'b1;
      st_q.awReady <= 1'b1;
      st_q.wReady <= 1'b1;
      st_q.arReady <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign awready = st_q.awReady;
  assign wready = st_q.wReady;
  assign bvalid = st_q.bValid;
  assign bresp = st_q.bResp;
  assign arready = st_q.arReady;
  assign rvalid = st_q.rValid;
  assign rdata = st_q.rData;
  assign rresp = st_q.rResp;
  assign intDivide = st_q.intDivide;
  assign modulusKindSelect = st_q.modKind;
  assign fixedModulusActive = st_q.fixedMod;
  assign fracOneActive = st_q.frac1;
  assign fracTwoActive = st_q.frac2;
  assign modTwoActive = st_q.mod2;
  assign functionSettings = st_q.funcSet;
  assign secondClockSettings = st_q.clk2Set;
  assign updatePulse = st_q.update;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  property p_freqOnlyOnInt;
    @(posedge clock) disable iff (!rst_b)
      !(doWrite && wordSel == SEL_INT && st_q.awAddr == OFS_CTRL_WORD)
      |=> $stable(fracOneActive) && $stable(intDivide);
  endproperty
  a_freqOnlyOnInt: assert property (p_freqOnlyOnInt)
    else $error("active setting changed without integer write");

  property p_fixedMod;
    @(posedge clock) disable iff (!rst_b)
      updatePulse && !modulusKindSelect |-> fixedModulusActive;
  endproperty
  a_fixedMod: assert property (p_fixedMod)
    else $error("fixed modulus not selected");

  property p_varMod;
    @(posedge clock) disable iff (!rst_b)
      modulusKindSelect |-> !fixedModulusActive;
  endproperty
  a_varMod: assert property (p_varMod)
    else $error("variable modulus not selected");

  property p_intField;
    @(posedge clock) disable iff (!rst_b)
      doWrite && wordSel == SEL_INT && st_q.awAddr == OFS_CTRL_WORD
      |=> intDivide == $past(st_q.wData[19:4]) && updatePulse;
  endproperty
  a_intField: assert property (p_intField)
    else $error("integer divide value not taken from bits 19 to 4");

  property p_holdStage;
    @(posedge clock) disable iff (!rst_b)
      doWrite && wordSel == SEL_FRAC1 && st_q.awAddr == OFS_CTRL_WORD
      |=> $stable(fracOneActive) && st_q.shadow[1] == $past(st_q.wData);
  endproperty
  a_holdStage: assert property (p_holdStage)
    else $error("held field acted directly");

  property p_rsvdFlag;
    @(posedge clock) disable iff (!rst_b)
      doWrite && st_q.awAddr == OFS_CTRL_WORD && wordSel == SEL_RSV13
      && st_q.wData[31:4] != 28'h0 |=> st_q.rsvdViolation;
  endproperty
  a_rsvdFlag: assert property (p_rsvdFlag)
    else $error("reserved word nonzero not flagged");

  property p_groupApply;
    @(posedge clock) disable iff (!rst_b)
      updatePulse |-> functionSettings == st_q.shadow[6]
      || $past(st_q.shadow[6]) == functionSettings;
  endproperty
  a_groupApply: assert property (p_groupApply)
    else $error("function settings not applied on update");

  property p_selectRoute;
    @(posedge clock) disable iff (!rst_b)
      doWrite && st_q.awAddr == OFS_CTRL_WORD && wordSel == SEL_CLK2
      |=> $stable(st_q.shadow[6]) && st_q.shadow[7] == $past(st_q.wData);
  endproperty
  a_selectRoute: assert property (p_selectRoute)
    else $error("word routed to wrong register");

  property p_bresp;
    @(posedge clock) disable iff (!rst_b)
      doWrite |=> bvalid && (bresp == RESP_OKAY || bresp == RESP_SLVERR);
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing");

  // A read request is answered on the next edge
  property p_readAnswer;
    @(posedge clock) disable iff (!rst_b)
      arvalid && arready |=> rvalid;
  endproperty
  a_readAnswer: assert property (p_readAnswer)
    else $error("read response missing");

  // Update pulse only follows an accepted integer word
  property p_pulseCause;
    @(posedge clock) disable iff (!rst_b)
      updatePulse |-> $past(intWrite);
  endproperty
  a_pulseCause: assert property (p_pulseCause)
    else $error("update pulse without integer write");

  // Held fraction and modulus words move to the outputs with the update
  property p_frac2Apply;
    @(posedge clock) disable iff (!rst_b)
      updatePulse |-> fracTwoActive == $past(st_q.shadow[3][27:4])
      && modTwoActive == $past(st_q.shadow[4][27:4]);
  endproperty
  a_frac2Apply: assert property (p_frac2Apply)
    else $error("held fraction or modulus not applied on update");

  // Second clock word moves to its output with the update
  property p_clk2Apply;
    @(posedge clock) disable iff (!rst_b)
      updatePulse |-> secondClockSettings == $past(st_q.shadow[7]);
  endproperty
  a_clk2Apply: assert property (p_clk2Apply)
    else $error("second clock settings not applied on update");

  // Nonzero data in reserved word 8 or 10 is flagged
  property p_rsvdEight;
    @(posedge clock) disable iff (!rst_b)
      doWrite && st_q.awAddr == OFS_CTRL_WORD && st_q.wData[31:4] != 28'h0
      && (wordSel == SEL_RSV8 || wordSel == SEL_RSV10) |=> st_q.rsvdViolation;
  endproperty
  a_rsvdEight: assert property (p_rsvdEight)
    else $error("reserved word eight or ten nonzero not flagged");

  // Violation flag stays set until reset
  property p_rsvdSticky;
    @(posedge clock) disable iff (!rst_b)
      st_q.rsvdViolation |=> st_q.rsvdViolation;
  endproperty
  a_rsvdSticky: assert property (p_rsvdSticky)
    else $error("reserved violation flag lost");

  // Unknown select codes are refused and store nothing
  property p_badSelect;
    @(posedge clock) disable iff (!rst_b)
      doWrite && int'(wordSel) >= NUM_WORDS
      |=> bresp == RESP_SLVERR && $stable(st_q.shadow);
  endproperty
  a_badSelect: assert property (p_badSelect)
    else $error("unknown select code not refused");

  // Integer readback carries the active value
  property p_readInt;
    @(posedge clock) disable iff (!rst_b)
      arvalid && arready && araddr == OFS_ACTIVE_INT
      |=> rdata[15:0] == $past(intDivide) && rdata[28] == $past(modulusKindSelect);
  endproperty
  a_readInt: assert property (p_readInt)
    else $error("integer readback wrong");

  c_intWrite: cover property (@(posedge clock) disable iff (!rst_b) updatePulse);
  c_varMod: cover property (@(posedge clock) disable iff (!rst_b)
    updatePulse && modulusKindSelect);
  c_rsvd: cover property (@(posedge clock) disable iff (!rst_b)
    st_q.rsvdViolation);
  c_read: cover property (@(posedge clock) disable iff (!rst_b) rvalid && rready);
  c_slvErr: cover property (@(posedge clock) disable iff (!rst_b) bvalid && bresp == RESP_SLVERR);

endmodule : scrm_regmap
